// >>> bench/ifeu_chk.sv
`timescale 1ns/10ps
module ifeu_chk (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   // zero-page bus
   input wire ifeu_pkg::ifeu_bus_req_s BUS_REQ_I,
   input wire logic [7:0] BUS_RDATA_O,
   input wire logic BUS_RVALID_O,
   // request to the cpu core
   input wire logic IRQ_N_O
);
   import ifeu_pkg::*;
   // short names for the bus fields
   wire logic r = BUS_REQ_I.rd;
   wire logic w = BUS_REQ_I.wr;
   wire logic [7:0] a = BUS_REQ_I.addr;
   wire logic [7:0] d = BUS_REQ_I.wdata;
   wire logic v = BUS_RVALID_O;
   wire logic [7:0] q = BUS_RDATA_O;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   alias_read_a:
      assert property (r && a == 8'h10 |=> v && q == 8'hFF) else $error("alias");
   flag_read_a:
      assert property (r && a == 8'h11 |=> v) else $error("flag read");
   unmapped_read_a:
      assert property (r && a == 8'h18 |=> !v && q == 8'h00) else $error("unmap");
   no_read_a:
      assert property (!r |=> !v && q == 8'h00) else $error("idle read");
   enable_wr_a:
      assert property (w && a == 8'h12 ##1 r && a == 8'h12
         |=> q == $past(d, 2)) else $error("enable write");
   enable_hold_a:
      assert property (r && a == 8'h12 ##1 r && a == 8'h12
         |=> q == $past(q)) else $error("enable hold");
   reset_quiet_a:
      assert property (disable iff (1'b0) !RESET_N_I |=> IRQ_N_O && !v)
         else $error("reset");
   irq_mask_a:
      assert property (w && a == 8'h12 && d == 8'h00 |=> IRQ_N_O)
         else $error("masked irq");
endmodule

// >>> bench/ifeu_cpu_model.sv
`timescale 1ns/10ps
module ifeu_cpu_model (
   // clock
   input wire logic clk_i,
   // zero-page bus request
   output ifeu_pkg::ifeu_bus_req_s req_o
);
   import ifeu_pkg::*;
   initial req_o = '0;
   // one bus cycle, held until the next falling edge
   task cyc(logic rd, logic wr, logic [7:0] ad, logic [7:0] dt);
      @(negedge clk_i);
      req_o = '{rd, wr, ad, dt};
   endtask
   // released bus: strobes low, address and data toggled
   task idle;
      @(negedge clk_i);
      req_o = '{1'b0, 1'b0, ~req_o.addr, ~req_o.wdata};
   endtask
   // bit-clear instruction: alias read, then masked write
   task bit_clear_instruction(int b);
      cyc(1'b1, 1'b0, 8'h10, 8'h00);
      cyc(1'b0, 1'b1, 8'h10, ~(8'h01 << b));
      idle;
   endtask
endmodule

// >>> bench/testbench.sv
`timescale 1ns/10ps
module testbench;
   import ifeu_pkg::*;
   logic clk = 0, rst_n = 0, ua = 0, ub = 0, v, irq_n;
   logic [3:0] pa = 4'hC;
   logic [7:0] ss = 0, rdata, en;
   ifeu_bus_req_s req;
   logic [7:0] q[$];
   int err_total = 0, checked = 0;
   // clock and parts
   always #10 clk = ~clk;
   ifeu_cpu_model ifeu_cpu_model_i (.clk_i(clk), .req_o(req));
   ifeu_top ifeu_top_i (.REF_CLK_I(clk), .RESET_N_I(rst_n),
      .BUS_REQ_I(req), .BUS_RDATA_O(rdata), .BUS_RVALID_O(v),
      .PORT_A_I(pa), .CNTA_UNDERFLOW_I(ua), .CNTB_UNDERFLOW_I(ub),
      .SERIAL_STATUS_I(ss), .IRQ_N_O(irq_n));
   // compare and count
   task chk(string n, logic [7:0] e, logic [7:0] g);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task give_verdict;
      if (err_total == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // bus cycles; reads note their expectation
   task rd(logic [7:0] ad, logic [7:0] e);
      q.push_back(e);
      ifeu_cpu_model_i.cyc(1'b1, 1'b0, ad, 8'h00);
      ifeu_cpu_model_i.idle;
   endtask
   task wr(logic [7:0] ad, logic [7:0] dt);
      ifeu_cpu_model_i.cyc(1'b0, 1'b1, ad, dt);
      ifeu_cpu_model_i.idle;
   endtask
   // read data watcher takes the oldest note
   always @(negedge clk)
      if (v === 1'b1) chk("rdata", q.size() ? q.pop_front() : 8'hXX, rdata);
   // hang guard
   initial begin
      #200000;
      err_total++;
      give_verdict;
   end
   // main sequence
   initial begin
      void'($urandom(12154));
      repeat (6) @(negedge clk);
      rst_n = 1;
      rd(8'h11, 8'h00);
      rd(8'h12, 8'h00);
      rd(8'h10, 8'hFF);
      en = $urandom;
      q.push_back(en);
      q.push_back(en);
      ifeu_cpu_model_i.cyc(1'b0, 1'b1, 8'h12, en);
      ifeu_cpu_model_i.cyc(1'b1, 1'b0, 8'h12, 8'h00);
      ifeu_cpu_model_i.cyc(1'b1, 1'b0, 8'h12, 8'h00);
      ifeu_cpu_model_i.idle;
      @(negedge clk) {pa, ua, ub, ss} = {4'h3, 2'b11, 8'h41};
      @(negedge clk) {ua, ub} = 2'b00;
      repeat (5) @(negedge clk);
      rd(8'h11, 8'hFF);
      chk("irq_n", {7'h0, ~|en}, {7'h0, irq_n});
      q.push_back(8'hFF);
      ifeu_cpu_model_i.bit_clear_instruction(0);
      rd(8'h11, 8'hFE);
      wr(8'h11, 8'h05);
      rd(8'h11, 8'hF4);
      ifeu_cpu_model_i.cyc(1'b1, 1'b0, 8'h18, 8'h00);
      wr(8'h1E, 8'h00);
      rd(8'h11, 8'hC4);
      @(negedge clk) ss = 8'h60;
      rd(8'h11, 8'h04);
      @(negedge clk) ss = 8'h80;
      rd(8'h11, 8'h84);
      wr(8'h12, 8'h84);
      q.push_back(8'hFF);
      ifeu_cpu_model_i.bit_clear_instruction(2);
      chk("irq_n", 8'h00, {7'h0, irq_n});
      @(negedge clk) {pa, ss} = {4'hC, 8'h00};
      repeat (4) @(negedge clk);
      chk("irq_n", 8'h01, {7'h0, irq_n});
      @(negedge clk) ua = 1;
      @(negedge clk) ua = 0;
      wr(8'h12, 8'h00);
      wr(8'h12, 8'hFF);
      // line 1 rises so its flag lands on the bit-clear write edge
      q.push_back(8'hFF);
      @(negedge clk) pa = 4'hE;
      ifeu_cpu_model_i.bit_clear_instruction(1);
      rd(8'h11, 8'h12);
      chk("irq_n", 8'h00, {7'h0, irq_n});
      @(negedge clk) rst_n = 0;
      repeat (2) @(negedge clk);
      rst_n = 1;
      rd(8'h11, 8'h00);
      rd(8'h12, 8'h00);
      repeat (2) @(negedge clk);
      give_verdict;
   end
endmodule
bind ifeu_top ifeu_chk ifeu_chk_i (.REF_CLK_I, .RESET_N_I, .BUS_REQ_I,
   .BUS_RDATA_O, .BUS_RVALID_O, .IRQ_N_O);

// >>> hdl/ifeu_defines.svh
// Summary of operation
// - Eight sources, each with own flag bit and enable bit, any mix requests.
// - Request stays asserted until every enabled pending flag is cleared.
// - Reading 0x11 returns the flag byte without disturbing any flag.
// - Alias 0x10 reads all ones; its bit-clear write lands on the flags.
// - Edge flag set after the read cycle survives the following write cycle.
// - Writing edge flags: a one is ignored, a zero clears that flag.
// - Writing 0x12 sets enable bits written one, clears those written zero.
// - Chip reset clears every enable bit.
// - Request asserted whenever some flag is true and its enable is set.
// - Flags 0,1 set on rising edge of port A lines 0,1; cleared by write.
// - Flags 2,3 set on falling edge of port A lines 2,3; cleared by write.
// - Flag 4 sets on counter A underflow; cleared reading 0x18 or writing 0x1A.
// - Flag 5 sets on counter B underflow; cleared reading 0x1C or writing 0x1E.
// - Flag 6 follows OR of serial status bits 0 to 3.
// - Flag 7 true when status 6 set with status 5 clear, or status 7 set.
// - Chip reset clears all four edge flags and all other flags.
// - Edges need only be caught at up to half the clock rate.
`ifndef IFEU_DEFINES_SVH
`define IFEU_DEFINES_SVH

// zero-page addresses
`define IFEU_ADDR_ALIAS 8'h10
`define IFEU_ADDR_FLAG 8'h11
`define IFEU_ADDR_ENABLE 8'h12
`define IFEU_ADDR_CNTA_LOW 8'h18
`define IFEU_ADDR_CNTA_WR 8'h1A
`define IFEU_ADDR_CNTB_LOW 8'h1C
`define IFEU_ADDR_CNTB_WR 8'h1E

// read values and reset values
`define IFEU_ALIAS_READ 8'hFF
`define IFEU_UNMAPPED_READ 8'h00
`define IFEU_FLAG_RESET 8'h00
`define IFEU_ENABLE_RESET 8'h00

// flag bit positions
`define IFEU_BIT_CNTA 4
`define IFEU_BIT_CNTB 5
`define IFEU_BIT_RX 6
`define IFEU_BIT_TX 7
`define IFEU_NUM_EDGE 4
`define IFEU_NUM_RISING 2

// serial status bit positions
`define IFEU_SER_RX_LO 0
`define IFEU_SER_RX_HI 3
`define IFEU_SER_TX_IDLE 5
`define IFEU_SER_TX_EMPTY 6
`define IFEU_SER_TX_DONE 7

`endif

// >>> hdl/ifeu_edge_det.sv
`timescale 1ns/10ps
module ifeu_edge_det #(
   parameter bit RISING = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // port line and detected edge
   input wire logic line_i,
   output logic edge_o
);
   import ifeu_pkg::*;

   ifeu_edge_s state_reg;
   ifeu_edge_s state_next;

   // two-flop synchroniser then one history flop
   always_comb begin
      state_next = state_reg;
      state_next.sync1 = line_i;
      state_next.sync2 = state_reg.sync1;
      state_next.prev = state_reg.sync2;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // one-cycle pulse per qualifying transition
   always_comb begin
      if (RISING) begin
         edge_o = state_reg.sync2 & ~state_reg.prev;
      end else begin
         edge_o = ~state_reg.sync2 & state_reg.prev;
      end
   end
endmodule

// >>> hdl/ifeu_pkg.sv
package ifeu_pkg;

   // zero-page bus request from the cpu core
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ifeu_bus_req_s;

   // state of one edge detector
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic prev;
   } ifeu_edge_s;

   // state of the flag and enable unit
   typedef struct packed {
      logic [7:0] flag;
      logic [7:0] enable;
      logic [7:0] rdata;
      logic rvalid;
      logic irq_n;
   } ifeu_state_s;

endpackage

// >>> hdl/ifeu_top.sv
`timescale 1ns/10ps
`include "ifeu_defines.svh"
module ifeu_top (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   // zero-page bus
   input wire ifeu_pkg::ifeu_bus_req_s BUS_REQ_I,
   output logic [7:0] BUS_RDATA_O,
   output logic BUS_RVALID_O,
   // interrupt sources
   input wire logic [3:0] PORT_A_I,
   input wire logic CNTA_UNDERFLOW_I,
   input wire logic CNTB_UNDERFLOW_I,
   input wire logic [7:0] SERIAL_STATUS_I,
   // request to the cpu core
   output logic IRQ_N_O
);
   import ifeu_pkg::*;

   ifeu_state_s state_reg;
   ifeu_state_s state_next;

   logic [3:0] edge_hit;
   logic [7:0] set_vec;
   logic [7:0] clr_vec;
   logic wr_flag;
   logic rd_alias;
   logic rd_flag;
   logic rd_enable;
   logic wr_enable;
   logic clr_cnta;
   logic clr_cntb;
   logic rx_level;
   logic tx_level;

   // edge detectors on port A lines 0 to 3
   genvar gi;
   generate
      for (gi = 0; gi < `IFEU_NUM_EDGE; gi = gi + 1) begin : g_edge
         ifeu_edge_det #(
            .RISING(gi < `IFEU_NUM_RISING)
         ) u_edge (
            .clk_i(REF_CLK_I),
            .reset_n_i(RESET_N_I),
            .line_i(PORT_A_I[gi]),
            .edge_o(edge_hit[gi])
         );
      end
   endgenerate

   // address decode of the zero-page accesses
   always_comb begin
      rd_alias = BUS_REQ_I.rd && (BUS_REQ_I.addr == `IFEU_ADDR_ALIAS);
      rd_flag = BUS_REQ_I.rd && (BUS_REQ_I.addr == `IFEU_ADDR_FLAG);
      rd_enable = BUS_REQ_I.rd && (BUS_REQ_I.addr == `IFEU_ADDR_ENABLE);
      wr_enable = BUS_REQ_I.wr && (BUS_REQ_I.addr == `IFEU_ADDR_ENABLE);
      // bit-clear write may arrive on the alias or on the flag address
      wr_flag = BUS_REQ_I.wr &&
         ((BUS_REQ_I.addr == `IFEU_ADDR_ALIAS) ||
          (BUS_REQ_I.addr == `IFEU_ADDR_FLAG));
   end

   // counter flag side-effect clears
   always_comb begin
      clr_cnta = (BUS_REQ_I.rd &&
                  (BUS_REQ_I.addr == `IFEU_ADDR_CNTA_LOW)) ||
                 (BUS_REQ_I.wr &&
                  (BUS_REQ_I.addr == `IFEU_ADDR_CNTA_WR));
      clr_cntb = (BUS_REQ_I.rd &&
                  (BUS_REQ_I.addr == `IFEU_ADDR_CNTB_LOW)) ||
                 (BUS_REQ_I.wr &&
                  (BUS_REQ_I.addr == `IFEU_ADDR_CNTB_WR));
   end

   // serial status levels
   always_comb begin
      rx_level = |SERIAL_STATUS_I[`IFEU_SER_RX_HI:`IFEU_SER_RX_LO];
      tx_level = (SERIAL_STATUS_I[`IFEU_SER_TX_EMPTY] &
                  ~SERIAL_STATUS_I[`IFEU_SER_TX_IDLE]) |
                 SERIAL_STATUS_I[`IFEU_SER_TX_DONE];
   end

   // set and clear vectors for the event flags
   always_comb begin
      set_vec = 8'h00;
      clr_vec = 8'h00;
      // edge flags: zero written clears, one written is ignored
      set_vec[3:0] = edge_hit;
      if (wr_flag) begin
         clr_vec[3:0] = ~BUS_REQ_I.wdata[3:0];
      end
      // counter underflow flags
      set_vec[`IFEU_BIT_CNTA] = CNTA_UNDERFLOW_I;
      set_vec[`IFEU_BIT_CNTB] = CNTB_UNDERFLOW_I;
      clr_vec[`IFEU_BIT_CNTA] = clr_cnta;
      clr_vec[`IFEU_BIT_CNTB] = clr_cntb;
   end

   // next state of flags, enables, read data and request
   always_comb begin
      state_next = state_reg;
      // set wins over clear in the same cycle
      state_next.flag[5:0] = (state_reg.flag[5:0] & ~clr_vec[5:0]) |
                             set_vec[5:0];
      // serial flags follow their status levels
      state_next.flag[`IFEU_BIT_RX] = rx_level;
      state_next.flag[`IFEU_BIT_TX] = tx_level;
      // enable register written whole
      if (wr_enable) begin
         state_next.enable = BUS_REQ_I.wdata;
      end
      // read data, registered; unmapped reads answer zero
      state_next.rvalid = rd_alias | rd_flag | rd_enable;
      if (rd_alias) begin
         state_next.rdata = `IFEU_ALIAS_READ;
      end else if (rd_flag) begin
         state_next.rdata = state_reg.flag;
      end else if (rd_enable) begin
         state_next.rdata = state_reg.enable;
      end else begin
         state_next.rdata = `IFEU_UNMAPPED_READ;
      end
      // level request held while any enabled flag is pending
      state_next.irq_n = ~|(state_next.flag & state_next.enable);
   end

   // single state register
   always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         state_reg.flag <= `IFEU_FLAG_RESET;
         state_reg.enable <= `IFEU_ENABLE_RESET;
         state_reg.rdata <= `IFEU_UNMAPPED_READ;
         state_reg.rvalid <= 1'b0;
         state_reg.irq_n <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign BUS_RDATA_O = state_reg.rdata;
   assign BUS_RVALID_O = state_reg.rvalid;
   assign IRQ_N_O = state_reg.irq_n;
endmodule
